// ==== src/hubctl_idle_mon.sv ====
// bus idle monitor for one clock and data line pair
`timescale 1ns/100ps
module hubctl_idle_mon #(
  parameter int IDLE_CYC = hubctl_pkg::IDLE_CYC
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      idle_q
);
  import hubctl_pkg::*;

  typedef enum logic [1:0] {
    MON_SETTLE = 2'b00,
    MON_BUSY   = 2'b01,
    MON_IDLE   = 2'b10
  } hubctl_mon_state_t;

  logic [2:0]        scl_sync_q;
  logic [2:0]        sda_sync_q;
  logic              start_det;
  logic              stop_det;
  logic              both_high;
  hubctl_mon_state_t state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              idle_d;

  // two flops before use; third stage only for edge detection
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
    end
  end

  // start and stop are data edges while clock stays high
  assign both_high = scl_sync_q[1] & sda_sync_q[1];
  assign start_det = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[2] & ~sda_sync_q[1];
  assign stop_det  = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[2] & sda_sync_q[1];

  // after reset the bus state is unknown, so it must first stay high for a while
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      MON_SETTLE: begin
        if (!both_high || start_det) begin
          state_d = MON_BUSY;
          cnt_d   = '0;
        end else if (cnt_q == CNT_W'(IDLE_CYC - 1)) begin
          state_d = MON_IDLE;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      MON_BUSY: begin
        if (stop_det) begin
          state_d = MON_SETTLE;
          cnt_d   = '0;
        end
      end
      MON_IDLE: begin
        // any low ends idle; a start always begins with a data fall
        if (!both_high) begin
          state_d = MON_BUSY;
        end
      end
    endcase
    idle_d = (state_d == MON_IDLE);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= MON_SETTLE;
      cnt_q   <= '0;
      idle_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      idle_q  <= idle_d;
    end
  end

  chk_start_ends_idle: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
    start_det |=> !idle_q) else $error("idle still shown after a start");
  chk_idle_needs_high: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
    $rose(idle_q) |-> $past(both_high, 1) && $past(both_high, 2))
    else $error("idle raised while a line was low");
  cov_idle_reached: cover property (@(posedge mclk) disable iff (reset) stop_det ##[1:200] idle_q);
endmodule

// ==== src/hubctl_pkg.sv ====
// package with constants for the hub port enable controller
// Operation
// RULE1 - hub enable inputs are active high and default enabled by a pullup
// RULE2 - a low enable isolates that port's data and clock lines from the hub
// RULE3 - the enable driver changes an enable only while hub and port are idle
// RULE4 - enable inputs may be wire-ORed from several open-drain drivers
// RULE5 - four open-drain link lines are shared by all hubs as one bus
// RULE6 - the master port has no enable and always belongs to the hub
// RULE7 - each enabled port joins the master port, each disabled one is cut off
// RULE8 - a falling port line drives the first link line low and pulls other ports
// RULE9 - data link lines follow port data lines at two thresholds
// RULE10 - clock link lines follow port clock lines at the same two thresholds
// RULE11 - second data link line releases when last externally held line rises
// RULE12 - the last rising data line is held at repeater low until decided
// RULE13 - first data link line releases after the second, on time or threshold
// RULE14 - remaining port data lines rise only after both data link lines high
// RULE15 - the same release order applies to the clock lines
// RULE16 - external drivers must pull lower than the repeater low to arbitrate
// RULE17 - only externally driven lows count toward link lines and last-rise
package hubctl_pkg;
  localparam int          NPORT     = 4;     // ports with an enable pin
  localparam int          CLK_NS    = 4;     // mclk period
  localparam int          HOLD_NS   = 300;   // enable hold after a stop
  localparam int          SETUP_NS  = 300;   // enable setup before a start
  // least times round up to whole cycles
  localparam int          IDLE_NS   = (HOLD_NS > SETUP_NS) ? HOLD_NS : SETUP_NS;
  localparam int          IDLE_CYC  = (IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W     = 8;
  localparam logic [3:0]  EN_RESET  = 4'hf;  // pullup default: all enabled
endpackage

// ==== src/hubctl_top.sv ====
// enable controller that gates the hub's switchable ports only while idle
`timescale 1ns/100ps
module hubctl_top #(
  parameter int NPORT    = hubctl_pkg::NPORT,
  parameter int IDLE_CYC = hubctl_pkg::IDLE_CYC
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [NPORT-1:0] enable_req,
  input  wire logic             master_port_clock_line_in,
  input  wire logic             master_port_data_line_in,
  input  wire logic [NPORT-1:0] port_clock_line_n_in,
  input  wire logic [NPORT-1:0] port_data_line_n_in,
  input  wire logic             hub_data_link_first_in,
  input  wire logic             hub_clock_link_first_in,
  input  wire logic [NPORT-1:0] port_enable_n_in,
  output logic      [NPORT-1:0] port_enable_n_o,
  output logic      [NPORT-1:0] port_enable_n_oe,
  output logic      [NPORT-1:0] enable_state_q,
  output logic      [NPORT-1:0] enable_seen_q,
  output logic                  hub_idle_q,
  output logic                  change_done_q
);
  import hubctl_pkg::*;

  logic [1:0]       link_sync_q [2];
  logic             link_high;
  logic [NPORT-1:0] en_sync1_q;
  logic [NPORT-1:0] en_sync2_q;
  logic             master_idle;
  logic [NPORT-1:0] local_idle;
  logic [NPORT-1:0] apply;
  logic [NPORT-1:0] state_d;
  logic [NPORT-1:0] oe_d;
  logic             hub_idle_d;
  logic             change_d;

  // link lines are only watched, never driven: another hub may own them
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      link_sync_q[0] <= 2'h3;
      link_sync_q[1] <= 2'h3;
      en_sync1_q     <= '1;
      en_sync2_q     <= '1;
    end else begin
      link_sync_q[0] <= {link_sync_q[0][0], hub_data_link_first_in};
      link_sync_q[1] <= {link_sync_q[1][0], hub_clock_link_first_in};
      en_sync1_q     <= port_enable_n_in;
      en_sync2_q     <= en_sync1_q;
    end
  end

  // any hub pulling a first link line means traffic somewhere on the hub
  assign link_high = link_sync_q[0][1] & link_sync_q[1][1]; // [RULE5]

  // the master port is always in the hub, so it sees all global traffic
  hubctl_idle_mon #(
    .IDLE_CYC (IDLE_CYC)
  ) u_master_mon (
    .mclk     (mclk),
    .reset    (reset),
    .scl_in   (master_port_clock_line_in),
    .sda_in   (master_port_data_line_in),
    .idle_q   (master_idle)
  ); // [RULE6]

  // each spoke segment is watched on its own, even while isolated
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    hubctl_idle_mon #(
      .IDLE_CYC (IDLE_CYC)
    ) u_local_mon (
      .mclk     (mclk),
      .reset    (reset),
      .scl_in   (port_clock_line_n_in[i]),
      .sda_in   (port_data_line_n_in[i]),
      .idle_q   (local_idle[i])
    );
  end

  // a pending change waits for hub and port to be idle; a request that
  // toggles back meanwhile is simply never applied
  always_comb begin
    hub_idle_d = master_idle & link_high;
    apply      = (enable_req ^ enable_state_q) & local_idle & {NPORT{hub_idle_q}}; // [RULE3]
    state_d    = (enable_state_q & ~apply) | (enable_req & apply); // [RULE3]
    // open drain: pull low to disable, release to let the pullup enable
    oe_d       = ~state_d; // [RULE4]
    change_d   = |apply;
  end

  // pin drive and status are all registered; output value is always low
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enable_state_q   <= NPORT'(EN_RESET); // [RULE1]
      port_enable_n_oe <= ~NPORT'(EN_RESET);
      port_enable_n_o  <= '0;
      enable_seen_q    <= NPORT'(EN_RESET);
      hub_idle_q       <= 1'b0;
      change_done_q    <= 1'b0;
    end else begin
      enable_state_q   <= state_d;
      port_enable_n_oe <= oe_d;
      port_enable_n_o  <= '0; // [RULE4]
      enable_seen_q    <= en_sync2_q; // wired level may be low from another driver
      hub_idle_q       <= hub_idle_d;
      change_done_q    <= change_d;
    end
  end

  // per-port checks: each switchable port is judged on its own
  for (genvar i = 0; i < NPORT; i++) begin : g_chk
    chk_change_when_idle: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      (enable_state_q[i] != $past(enable_state_q[i])) |-> $past(hub_idle_q && local_idle[i]))
      else $error("enable changed while bus busy");
    chk_pending_applied: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      (enable_req[i] != enable_state_q[i] && hub_idle_q && local_idle[i])
      |=> enable_state_q[i] == $past(enable_req[i]))
      else $error("idle bus but pending enable not applied");
    chk_open_drain_pin: assert property (@(posedge mclk) disable iff (reset) // [RULE4]
      !port_enable_n_o[i] && (port_enable_n_oe[i] == !enable_state_q[i]))
      else $error("enable pin not driven as open drain");

    // a port neither wanted nor enabled stays cut off
    chk_disabled_stays_off: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
      (!enable_req[i] && !enable_state_q[i])
      |=> !enable_state_q[i])
      else $error("disabled port enabled without a request");

    // an enabled port that is still wanted is never dropped
    chk_enabled_stays_on: assert property (@(posedge mclk) disable iff (reset) // [RULE1]
      (enable_req[i] && enable_state_q[i])
      |=> enable_state_q[i])
      else $error("enabled port dropped without a request");

    // with nothing pending the applied level must not move
    chk_no_stray_change: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      (enable_req[i] == enable_state_q[i])
      |=> $stable(enable_state_q[i]))
      else $error("enable moved with nothing pending");

    // every applied change takes the requested level, never a stale one
    chk_change_follows_req: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      (enable_state_q[i] != $past(enable_state_q[i]))
      |-> (enable_state_q[i] == $past(enable_req[i])))
      else $error("enable changed to a level not requested");

    // a busy spoke freezes its own bit even when the hub is idle
    chk_local_busy_holds: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      !local_idle[i]
      |=> $stable(enable_state_q[i]))
      else $error("enable moved while its port was busy");

    // another driver holding the wire low is tolerated, not fought
    chk_wired_low_kept: assert property (@(posedge mclk) disable iff (reset) // [RULE4]
      (enable_state_q[i] && enable_req[i] && !enable_seen_q[i])
      |=> (enable_state_q[i] && !port_enable_n_oe[i]))
      else $error("host reacted to a wired low on an enable pin");

    // our own pull reaches the readback after sync and register
    chk_cut_pin_low: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
      (!$past(reset, 3) && $past(port_enable_n_oe[i], 3))
      |-> !enable_seen_q[i])
      else $error("enable pin reads high while pulled low");
  end

  chk_link_blocks_idle: assert property (@(posedge mclk) disable iff (reset) // [RULE5]
    !link_high |=> !hub_idle_q) else $error("idle shown while link line low");
  chk_busy_holds_state: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
    !hub_idle_q |=> $stable(enable_state_q)) else $error("enable moved while hub busy");

  // hub-wide checks
  // the readback shows the wire level after two sync flops and one register
  chk_seen_follows_pin: assert property (@(posedge mclk) disable iff (reset) // [RULE4]
    !$past(reset, 3)
    |-> (enable_seen_q == $past(port_enable_n_in, 3)))
    else $error("enable readback does not follow the pin");

  // a busy master port alone holds every enable
  chk_master_gates_idle: assert property (@(posedge mclk) disable iff (reset) // [RULE6]
    !master_idle
    |=> !hub_idle_q)
    else $error("idle shown while the master port is busy");

  // idle is only ever shown after the master port was idle
  chk_idle_needs_master: assert property (@(posedge mclk) disable iff (reset) // [RULE6]
    hub_idle_q
    |-> $past(master_idle))
    else $error("idle shown without an idle master port");

  // the clock link line blocks idle just as the data link line does
  chk_clock_link_blocks: assert property (@(posedge mclk) disable iff (reset) // [RULE5]
    !link_sync_q[1][1]
    |=> !hub_idle_q)
    else $error("idle shown while the clock link line is low");

  // idle may only rise after both link lines were seen high
  chk_idle_needs_links: assert property (@(posedge mclk) disable iff (reset) // [RULE5]
    $rose(hub_idle_q)
    |-> $past(link_high))
    else $error("idle raised while a link line was low");

  // the status pulse marks exactly the cycles in which an enable moved
  chk_done_on_change: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
    change_done_q
    |-> (enable_state_q != $past(enable_state_q)))
    else $error("change pulse without an enable change");

  chk_change_has_done: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
    (enable_state_q != $past(enable_state_q))
    |-> change_done_q)
    else $error("enable change without a change pulse");

  // scenario covers
  cov_disable_port: cover property (@(posedge mclk) disable iff (reset)
    change_done_q && (enable_state_q != NPORT'(EN_RESET)));
  cov_reenable_port: cover property (@(posedge mclk) disable iff (reset)
    $rose(enable_state_q[0]));
  cov_wired_low: cover property (@(posedge mclk) disable iff (reset)
    enable_state_q[0] && !enable_seen_q[0]);
  // a request parked behind a busy spoke
  cov_held_while_busy: cover property (@(posedge mclk) disable iff (reset)
    !local_idle[1] && hub_idle_q && (enable_req[1] != enable_state_q[1]));
endmodule

// ==== verif/hubctl_hub_model.sv ====
// behavioural hub device seen from its enable and line pins
`timescale 1ns/100ps
module hubctl_hub_model (
  input  wire logic [3:0] drv_oe,
  input  wire logic [3:0] drv_o,
  input  wire logic [3:0] ext_en_lo,
  input  wire logic       m_scl_lo,
  input  wire logic       m_sda_lo,
  input  wire logic [3:0] s_scl_lo,
  input  wire logic [3:0] s_sda_lo,
  output logic      [3:0] en_pin,
  output logic            m_scl,
  output logic            m_sda,
  output logic      [3:0] s_scl,
  output logic      [3:0] s_sda,
  output logic            link_scl,
  output logic            link_sda
);
  logic [3:0] en;
  logic       any_scl;
  logic       any_sda;
  // pullup wins unless some open-drain driver pulls low
  assign en_pin = ~((drv_oe & ~drv_o) | ext_en_lo);
  assign en = en_pin;
  // only external lows on joined ports count; repeated lows never latch
  assign any_sda = m_sda_lo | |(s_sda_lo & en);
  assign any_scl = m_scl_lo | |(s_scl_lo & en);
  assign link_sda = ~any_sda;
  assign link_scl = ~any_scl;
  // release order collapses to one step in a digital model
  assign m_sda = ~any_sda;
  assign m_scl = ~any_scl;
  assign s_sda = (en & {4{~any_sda}}) | (~en & ~s_sda_lo);
  assign s_scl = (en & {4{~any_scl}}) | (~en & ~s_scl_lo);
endmodule

// ==== verif/hubctl_top_tb.sv ====
// self-checking bench for the hub enable controller
`timescale 1ns/100ps
module hubctl_top_tb;
  logic       mclk, reset, m_scl_lo, m_sda_lo, w_mscl, w_msda, l_scl, l_sda, idle, done;
  logic [3:0] req, ext_en_lo, s_scl_lo, s_sda_lo, en_pin, ws_scl, ws_sda, o, oe, st, seen;
  int         err_total, n_tests, cyc;
  hubctl_top #(.IDLE_CYC(4)) hubctl_top_i (.mclk(mclk), .reset(reset), .enable_req(req),
    .master_port_clock_line_in(w_mscl), .master_port_data_line_in(w_msda),
    .port_clock_line_n_in(ws_scl), .port_data_line_n_in(ws_sda),
    .hub_data_link_first_in(l_sda), .hub_clock_link_first_in(l_scl),
    .port_enable_n_in(en_pin), .port_enable_n_o(o), .port_enable_n_oe(oe),
    .enable_state_q(st), .enable_seen_q(seen), .hub_idle_q(idle), .change_done_q(done));
  hubctl_hub_model hubctl_hub_model_i (.drv_oe(oe), .drv_o(o), .ext_en_lo(ext_en_lo),
    .m_scl_lo(m_scl_lo), .m_sda_lo(m_sda_lo), .s_scl_lo(s_scl_lo), .s_sda_lo(s_sda_lo),
    .en_pin(en_pin), .m_scl(w_mscl), .m_sda(w_msda), .s_scl(ws_scl), .s_sda(ws_sda),
    .link_scl(l_scl), .link_sda(l_sda));
  task results;
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask
  // bounded wait for the one-cycle pulse, sampled after the edge settles
  task wait_done;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 200);
    chk("done", 4'h1, {3'h0, done});
  endtask
  task t_reset;
    chk("state", 4'hf, st);
    chk("oe", 4'h0, oe);
    chk("seen", 4'hf, seen);
    chk("idle", 4'h0, {3'h0, idle});
  endtask
  // disable port 1 only; a cut port's low must not reach the master
  task t_disable;
    req = 4'hd;
    wait_done;
    chk("state", 4'hd, st);
    chk("oe", 4'h2, oe);
    chk("o", 4'h0, o);
    chk("idle", 4'h1, {3'h0, idle});
    repeat (4) @(negedge mclk);
    chk("seen", 4'hd, seen);
    s_sda_lo = 4'h2;
    repeat (3) @(negedge mclk);
    chk("msda", 4'h1, {3'h0, w_msda});
    s_sda_lo = 4'h0;
  endtask
  // a start and a clock pulse hold the request until the stop
  task t_busy;
    m_sda_lo = 1'b1;
    repeat (3) @(negedge mclk);
    req = 4'hf;
    m_scl_lo = 1'b1;
    repeat (10) @(negedge mclk);
    chk("lscl", 4'h0, {3'h0, l_scl});
    chk("ssda", 4'h2, ws_sda);
    m_scl_lo = 1'b0;
    repeat (10) @(negedge mclk);
    chk("state", 4'hd, st);
    chk("idle", 4'h0, {3'h0, idle});
    m_sda_lo = 1'b0;
    wait_done;
    chk("state", 4'hf, st);
  endtask
  task t_wireor;
    @(negedge mclk);
    ext_en_lo = 4'h1;
    repeat (5) @(negedge mclk);
    chk("seen", 4'he, seen);
    chk("state", 4'hf, st);
    ext_en_lo = 4'h0;
  endtask
  // busy disabled spoke holds its own bit only; several bits in one cycle
  task t_split;
    @(negedge mclk);
    req = 4'hd;
    wait_done;
    @(negedge mclk);
    s_sda_lo = 4'h2;
    // let the spoke's busy state settle through its sync flops first
    repeat (4) @(negedge mclk);
    req = 4'he;
    wait_done;
    chk("state", 4'hc, st);
    repeat (20) @(negedge mclk);
    chk("state", 4'hc, st);
    s_sda_lo = 4'h0;
    wait_done;
    chk("state", 4'he, st);
    @(negedge mclk);
    req = 4'h1;
    wait_done;
    chk("state", 4'h1, st);
    chk("oe", 4'he, oe);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard well beyond the hundred or so cycles the scenarios need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      results;
    end
  end
  initial begin
    {reset, req, ext_en_lo, s_scl_lo, s_sda_lo} = {1'b1, 4'hf, 12'h000};
    {m_scl_lo, m_sda_lo, err_total, n_tests, cyc} = '0;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    t_reset;
    t_disable;
    t_busy;
    t_wireor;
    t_split;
    results;
  end
endmodule
